/* File: verilog/cpu_exec_cfg.svh */
`ifndef CPU_EXEC_CFG_SVH
`define CPU_EXEC_CFG_SVH

`define OP_COPY_DD 8'h4E
`define OP_COPY_DX 8'h5E
`define OP_COPY_ID 8'h6E
`define OP_COPY_XD 8'h7E
`define OP_PRODUCT 8'h42
`define OP_NO_OPERATION 8'h9D
`define OP_SWAP 8'h62
`define OP_OR_IMM 8'hAA
`define OP_OR_DIR 8'hBA
`define OP_PUSH_ACC 8'h87
`define OP_PUSH_HIGH 8'h8B
`define OP_PUSH_LOW 8'h89
`define OP_PULL_ACC 8'h86
`define OP_PULL_HIGH 8'h8A
`define OP_PULL_LOW 8'h88
`define OP_PREFIX 8'h9E

// read-modify-write family: high nibble is the mode, low nibble the operation
`define LN_NEGATE 4'h0
`define LN_ROT_LEFT 4'h9
`define LN_ROT_RIGHT 4'h6
`define HN_DIR 4'h3
`define HN_ACC 4'h4
`define HN_LOW 4'h5
`define HN_IX1 4'h6
`define HN_IX 4'h7

// cycles per instruction, the prefix cycle not included
`define CYC_INH 3'h1
`define CYC_RMW_OFS 3'h5
`define CYC_RMW_IX 3'h4
`define CYC_COPY_DD 3'h5
`define CYC_COPY_DX 3'h5
`define CYC_COPY_ID 3'h4
`define CYC_COPY_XD 3'h5
`define CYC_PRODUCT 3'h5
`define CYC_OR_IMM 3'h2
`define CYC_OR_DIR 3'h3
`define CYC_PUSH 3'h2
`define CYC_PULL 3'h3

`define SP_RESET 16'h00FF
`define FLAGS_RESET 8'h68
`define INDEX_STEP 16'h0001

`define FLAG_V 7
`define FLAG_H 4
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0

`endif

/* File: verilog/cpu_exec_pkg.sv */
`default_nettype none
package cpu_exec_pkg;
    typedef enum logic [1:0] {
        alu_pass = 2'b00,
        alu_negate = 2'b01,
        alu_rot_left = 2'b10,
        alu_rot_right = 2'b11
    } alu_op_t;

    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_t;

    typedef enum logic {
        st_boot = 1'b0,
        st_run = 1'b1
    } state_t;

    typedef enum logic [3:0] {
        md_inh = 4'b0000,
        md_prefix = 4'b0001,
        md_rmw = 4'b0010,
        md_copy_dd = 4'b0011,
        md_copy_dx = 4'b0100,
        md_copy_id = 4'b0101,
        md_copy_xd = 4'b0110,
        md_or_imm = 4'b0111,
        md_or_dir = 4'b1000,
        md_product = 4'b1001,
        md_push = 4'b1010,
        md_pull = 4'b1011
    } mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } bus_req_t;
endpackage
`default_nettype wire

/* File: verilog/rmw_alu.sv */
`default_nettype none
module rmw_alu import cpu_exec_pkg::*; (
    input wire alu_op_t op_i,
    input wire logic [7:0] opnd_i,
    input wire logic carry_i,
    output logic [7:0] res_o,
    output flags_t flags_o
);
    // one shared unit for negate, both rotations and plain moves
    always_comb
    begin
        res_o = opnd_i;
        flags_o.c = carry_i;
        case (op_i)
            alu_negate:
            begin
                res_o = 8'h00 - opnd_i;
                flags_o.c = (res_o != 8'h00);
            end
            alu_rot_left:
            begin
                res_o = {opnd_i[6:0], carry_i};
                flags_o.c = opnd_i[7];
            end
            alu_rot_right:
            begin
                res_o = {carry_i, opnd_i[7:1]};
                flags_o.c = opnd_i[0];
            end
            default:
            begin
                res_o = opnd_i;
            end
        endcase
        flags_o.n = res_o[7];
        flags_o.z = (res_o == 8'h00);
        // moves and or clear overflow; rotations take n xor c
        case (op_i)
            alu_negate: flags_o.v = res_o[7] & opnd_i[7];
            alu_rot_left: flags_o.v = res_o[7] ^ flags_o.c;
            alu_rot_right: flags_o.v = res_o[7] ^ flags_o.c;
            default: flags_o.v = 1'h0;
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/cpu_opcode_subset_exec.sv */
`default_nettype none
`include "cpu_exec_cfg.svh"
module cpu_opcode_subset_exec import cpu_exec_pkg::*; #(
    parameter logic [15:0] START_PC = 16'h0000
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [7:0] rdata_i,
    output bus_req_t bus_o,
    output logic done_o,
    output logic illegal_o,
    output logic [7:0] acc_o,
    output logic [15:0] index_o,
    output logic [15:0] sp_o,
    output logic [15:0] pc_o,
    output logic [7:0] flags_o
);
    state_t state, next_state;
    logic [7:0] op, next_op;
    logic pre, next_pre;
    logic [2:0] cyc, next_cyc;
    logic [7:0] ofs, next_ofs;
    logic [7:0] t, next_t;
    logic [7:0] a, next_a;
    logic [7:0] x, next_x;
    logic [7:0] h, next_h;
    logic [15:0] sp, next_sp;
    logic [15:0] pc, next_pc;
    logic [7:0] condition_flags, next_flags;
    mode_t mode;
    logic [3:0] hn;
    logic [3:0] ln;
    logic [15:0] ea;
    logic [2:0] step;
    logic has_ofs, fin, grab, upd, bad;
    alu_op_t alu_sel;
    logic [7:0] alu_in;
    logic [7:0] alu_res;
    flags_t alu_fl;
    bus_req_t bus;

    function automatic logic rmw_op(input logic [3:0] l);
        rmw_op = (l == `LN_NEGATE) || (l == `LN_ROT_LEFT) || (l == `LN_ROT_RIGHT);
    endfunction

    // the prefix only opens the stack-relative offset form
    function automatic mode_t decode(input logic [7:0] opc, input logic pfx);
        decode = md_inh;
        if (pfx)
        begin
            if (opc[7:4] == `HN_IX1 && rmw_op(opc[3:0]))
                decode = md_rmw;
        end
        else if (opc == `OP_PREFIX)
            decode = md_prefix;
        else if (rmw_op(opc[3:0]) && (opc[7:4] == `HN_DIR || opc[7:4] == `HN_IX1 ||
                 opc[7:4] == `HN_IX))
            decode = md_rmw;
        else
        begin
            case (opc)
                `OP_COPY_DD: decode = md_copy_dd;
                `OP_COPY_DX: decode = md_copy_dx;
                `OP_COPY_ID: decode = md_copy_id;
                `OP_COPY_XD: decode = md_copy_xd;
                `OP_OR_IMM: decode = md_or_imm;
                `OP_OR_DIR: decode = md_or_dir;
                `OP_PRODUCT: decode = md_product;
                `OP_PUSH_ACC, `OP_PUSH_HIGH, `OP_PUSH_LOW: decode = md_push;
                `OP_PULL_ACC, `OP_PULL_HIGH, `OP_PULL_LOW: decode = md_pull;
                default: decode = md_inh;
            endcase
        end
    endfunction

    function automatic logic [2:0] span(input mode_t m, input logic [3:0] n);
        case (m)
            md_rmw: span = (n == `HN_IX) ? `CYC_RMW_IX : `CYC_RMW_OFS;
            md_copy_dd: span = `CYC_COPY_DD;
            md_copy_dx: span = `CYC_COPY_DX;
            md_copy_id: span = `CYC_COPY_ID;
            md_copy_xd: span = `CYC_COPY_XD;
            md_or_imm: span = `CYC_OR_IMM;
            md_or_dir: span = `CYC_OR_DIR;
            md_product: span = `CYC_PRODUCT;
            md_push: span = `CYC_PUSH;
            md_pull: span = `CYC_PULL;
            default: span = `CYC_INH;
        endcase
    endfunction

    rmw_alu u_alu (
        .op_i(alu_sel),
        .opnd_i(alu_in),
        .carry_i(condition_flags[`FLAG_C]),
        .res_o(alu_res),
        .flags_o(alu_fl)
    );

    // one bus cycle per clock; the last cycle always fetches the next opcode
    always_comb
    begin
        mode = decode(op, pre);
        hn = op[7:4];
        ln = op[3:0];
        has_ofs = (hn != `HN_IX);
        step = has_ofs ? cyc - 3'h1 : cyc;
        if (pre)
            ea = sp + {8'h00, ofs};
        else if (hn == `HN_IX)
            ea = {h, x};
        else if (hn == `HN_IX1)
            ea = {h, x} + {8'h00, ofs};
        else
            ea = {8'h00, ofs};
        case (ln)
            `LN_NEGATE: alu_sel = alu_negate;
            `LN_ROT_LEFT: alu_sel = alu_rot_left;
            `LN_ROT_RIGHT: alu_sel = alu_rot_right;
            default: alu_sel = alu_pass;
        endcase
        alu_in = t;
        fin = (state == st_boot) || (mode != md_prefix && cyc == span(mode, hn) - 3'h1);
        grab = 1'h0;
        upd = 1'h0;
        bad = 1'h0;
        bus = '{addr: pc, wdata: 8'h00, we: 1'h0, re: 1'h0};
        next_state = state;
        next_op = op;
        next_pre = pre;
        next_cyc = cyc + 3'h1;
        next_ofs = ofs;
        next_t = t;
        next_a = a;
        next_x = x;
        next_h = h;
        next_sp = sp;
        next_pc = pc;
        next_flags = condition_flags;
        if (state == st_run)
        begin
            case (mode)
                md_prefix:
                begin
                    bus.re = 1'h1;
                    next_op = rdata_i;
                    next_pc = pc + 16'h0001;
                    next_pre = 1'h1;
                    next_cyc = 3'h0;
                end
                md_inh:
                begin
                    alu_in = (hn == `HN_LOW) ? x : a;
                    if (!pre && rmw_op(ln) && (hn == `HN_ACC || hn == `HN_LOW))
                    begin
                        upd = 1'h1;
                        if (hn == `HN_LOW)
                            next_x = alu_res;
                        else
                            next_a = alu_res;
                    end
                    else if (!pre && op == `OP_SWAP)
                        next_a = {a[3:0], a[7:4]};
                    else if (pre || op != `OP_NO_OPERATION)
                        bad = 1'h1; // unknown opcodes run as a one-cycle idle
                end
                md_rmw:
                begin
                    if (has_ofs && cyc == 3'h0)
                    begin
                        grab = 1'h1;
                        next_ofs = rdata_i;
                    end
                    else
                    begin
                        case (step)
                            3'h0:
                            begin
                                bus.addr = ea;
                                bus.re = 1'h1;
                                next_t = rdata_i;
                            end
                            3'h1:
                            begin
                                next_t = alu_res;
                                upd = 1'h1;
                            end
                            3'h2:
                            begin
                                bus.addr = ea;
                                bus.wdata = t;
                                bus.we = 1'h1;
                            end
                            default:
                            begin
                                bus.re = 1'h0;
                            end
                        endcase
                    end
                end
                md_copy_dd, md_copy_dx, md_copy_id, md_copy_xd:
                begin
                    // each form walks its own read, fetch and write order
                    if ((mode == md_copy_dd && (cyc == 3'h0 || cyc == 3'h2)) ||
                        (mode == md_copy_dx && cyc == 3'h0) ||
                        ((mode == md_copy_id || mode == md_copy_xd) && cyc == 3'h1))
                    begin
                        grab = 1'h1;
                        next_ofs = rdata_i;
                    end
                    else if (mode == md_copy_id && cyc == 3'h0)
                    begin
                        grab = 1'h1;
                        next_t = rdata_i;
                    end
                    else if ((mode == md_copy_dd || mode == md_copy_dx) && cyc == 3'h1)
                    begin
                        bus.addr = {8'h00, ofs};
                        bus.re = 1'h1;
                        next_t = rdata_i;
                    end
                    else if (mode == md_copy_xd && cyc == 3'h0)
                    begin
                        bus.addr = {h, x};
                        bus.re = 1'h1;
                        next_t = rdata_i;
                        {next_h, next_x} = {h, x} + `INDEX_STEP;
                    end
                    else if (cyc == span(mode, hn) - 3'h2)
                    begin
                        bus.addr = (mode == md_copy_dx) ? {h, x} : {8'h00, ofs};
                        bus.wdata = t;
                        bus.we = 1'h1;
                        upd = 1'h1;
                        if (mode == md_copy_dx)
                            {next_h, next_x} = {h, x} + `INDEX_STEP;
                    end
                end
                md_or_imm, md_or_dir:
                begin
                    if (mode == md_or_dir && cyc == 3'h0)
                    begin
                        grab = 1'h1;
                        next_ofs = rdata_i;
                    end
                    else if (!fin)
                    begin
                        // immediate reads the program stream, direct the page-zero byte
                        if (mode == md_or_imm)
                            grab = 1'h1;
                        else
                        begin
                            bus.addr = {8'h00, ofs};
                            bus.re = 1'h1;
                        end
                        alu_in = a | rdata_i;
                        next_a = alu_res;
                        upd = 1'h1;
                    end
                end
                md_product:
                begin
                    if (cyc == `CYC_PRODUCT - 3'h2)
                    begin
                        {next_x, next_a} = {8'h00, x} * {8'h00, a};
                        next_flags[`FLAG_H] = 1'h0;
                        next_flags[`FLAG_C] = 1'h0;
                    end
                end
                md_push:
                begin
                    if (cyc == 3'h0)
                    begin
                        bus.addr = sp;
                        bus.we = 1'h1;
                        case (op)
                            `OP_PUSH_HIGH: bus.wdata = h;
                            `OP_PUSH_LOW: bus.wdata = x;
                            default: bus.wdata = a;
                        endcase
                        next_sp = sp - 16'h0001;
                    end
                end
                md_pull:
                begin
                    // pointer moves first so the load sees the new top
                    if (cyc == 3'h0)
                        next_sp = sp + 16'h0001;
                    else if (cyc == 3'h1)
                    begin
                        bus.addr = sp;
                        bus.re = 1'h1;
                        case (op)
                            `OP_PULL_HIGH: next_h = rdata_i;
                            `OP_PULL_LOW: next_x = rdata_i;
                            default: next_a = rdata_i;
                        endcase
                    end
                end
                default:
                begin
                    bad = 1'h1;
                end
            endcase
        end
        if (grab)
        begin
            bus.re = 1'h1;
            bus.addr = pc;
            next_pc = pc + 16'h0001;
        end
        if (upd)
        begin
            next_flags[`FLAG_V] = alu_fl.v;
            next_flags[`FLAG_N] = alu_fl.n;
            next_flags[`FLAG_Z] = alu_fl.z;
            if (alu_sel != alu_pass)
                next_flags[`FLAG_C] = alu_fl.c;
        end
        if (fin)
        begin
            bus.re = 1'h1;
            bus.addr = pc;
            next_op = rdata_i;
            next_pc = pc + 16'h0001;
            next_cyc = 3'h0;
            next_pre = 1'h0;
            next_state = st_run;
        end
    end

    // sequencer state
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= st_boot;
            op <= `OP_NO_OPERATION;
            pre <= 1'h0;
            cyc <= 3'h0;
            ofs <= 8'h00;
            t <= 8'h00;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            pre <= next_pre;
            cyc <= next_cyc;
            ofs <= next_ofs;
            t <= next_t;
        end
    end

    // accumulator and index halves
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            a <= 8'h00;
            x <= 8'h00;
            h <= 8'h00;
        end
        else
        begin
            a <= next_a;
            x <= next_x;
            h <= next_h;
        end
    end

    // pointers and flags
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sp <= `SP_RESET;
            pc <= START_PC;
            condition_flags <= `FLAGS_RESET;
        end
        else
        begin
            sp <= next_sp;
            pc <= next_pc;
            condition_flags <= next_flags;
        end
    end

    // bus strobes are decoded from state only, so no input reaches them
    assign bus_o = bus;
    assign done_o = fin && (state == st_run);
    assign illegal_o = bad && (state == st_run);
    assign acc_o = a;
    assign index_o = {h, x};
    assign sp_o = sp;
    assign pc_o = pc;
    assign flags_o = condition_flags;

    logic at_start;
    assign at_start = (state == st_run) && (cyc == 3'h0) && !pre;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    a_copy_span: assert property (
        at_start && op == `OP_COPY_DD |-> !done_o [*4] ##1 done_o)
        else $error("direct copy length wrong");
    a_index_step: assert property (
        at_start && op == `OP_COPY_XD |=> index_o == $past(index_o) + 16'h0001)
        else $error("index not advanced");
    a_product_val: assert property (
        at_start && op == `OP_PRODUCT |-> ##4 done_o &&
        ({x, a} == ({8'h00, $past(x, 4)} * {8'h00, $past(a, 4)})))
        else $error("product wrong");
    a_negate_acc: assert property (
        at_start && op == {`HN_ACC, `LN_NEGATE} |=> a == 8'h00 - $past(a))
        else $error("negate wrong");
    a_idle_quiet: assert property (
        at_start && op == `OP_NO_OPERATION |-> done_o ##1
        ($stable(acc_o) && $stable(index_o) && $stable(sp_o) && $stable(flags_o)))
        else $error("idle changed state");
    a_nibble_swap: assert property (
        at_start && op == `OP_SWAP |=>
        a == {$past(a[3:0]), $past(a[7:4])} && $stable(flags_o))
        else $error("swap wrong");
    // the immediate form ends in the cycle right after its operand read
    a_or_flags: assert property (
        at_start && op == `OP_OR_IMM |=> a == ($past(a) | $past(rdata_i)) &&
        !flags_o[`FLAG_V] && flags_o[`FLAG_Z] == (a == 8'h00) && done_o)
        else $error("or result wrong");
    a_push_write: assert property (
        at_start && op == `OP_PUSH_ACC |-> bus_o.we && bus_o.addr == sp_o &&
        bus_o.wdata == acc_o ##1 done_o && sp_o == $past(sp_o) - 16'h0001)
        else $error("push wrong");
    a_pull_order: assert property (
        at_start && op == `OP_PULL_ACC |=>
        bus_o.re && bus_o.addr == $past(sp_o) + 16'h0001 ##1 done_o)
        else $error("pull order wrong");
    a_rot_left: assert property (
        at_start && op == {`HN_ACC, `LN_ROT_LEFT} |=>
        a == {$past(a[6:0]), $past(flags_o[`FLAG_C])} && flags_o[`FLAG_C] == $past(a[7]))
        else $error("rotate left wrong");
    a_rot_right: assert property (
        at_start && op == {`HN_ACC, `LN_ROT_RIGHT} |=>
        a == {$past(flags_o[`FLAG_C]), $past(a[7:1])} && flags_o[`FLAG_C] == $past(a[0]))
        else $error("rotate right wrong");
    a_prefix_span: assert property (
        (state == st_run) && !pre && op == `OP_PREFIX && rdata_i == {`HN_IX1, `LN_ROT_LEFT}
        |-> !done_o [*5] ##1 done_o)
        else $error("stack form length wrong");

    c_product: cover property (at_start && op == `OP_PRODUCT ##4 done_o);
    c_stack_form: cover property (pre && mode == md_rmw && bus_o.we);
    c_copy_index: cover property (at_start && op == `OP_COPY_XD);
    c_pull_high: cover property (at_start && op == `OP_PULL_HIGH ##2 done_o);
endmodule
`default_nettype wire

/* File: verification/bus_memory_model.sv */
`default_nettype none
module bus_memory_model import cpu_exec_pkg::*; (
    input wire logic mclk_i,
    input wire bus_req_t bus_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m [0:65535];
    logic [7:0] last = 8'h00;
    // zero-wait read; an idle bus shows the inverse of the last byte, never a stale copy
    assign rdata_o = bus_i.re ? m[bus_i.addr] : ~last;
    // one write per strobe, taken at the rising edge
    always @(posedge mclk_i)
    begin
        if (bus_i.we)
            m[bus_i.addr] <= bus_i.wdata;
        if (bus_i.re)
            last <= m[bus_i.addr];
    end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] rd, acc, flg, r1, r2, r3;
    logic [15:0] idx, spo, pco;
    logic done, ill;
    cpu_exec_pkg::bus_req_t bus;
    int error_cnt = 0;
    int n_compared = 0;
    int seed = 32'h580BA756;
    int cnt = 0;
    int ex;
    logic go = 1'b0;
    int cq[$];
    logic [15:0] pq[$];
    logic [7:0] em [0:511];
    logic [7:0] lo [3] = '{8'h00, 8'h09, 8'h06};
    logic [15:0] pc = 16'h0001;
    logic [15:0] sp = 16'h00FF;
    logic [15:0] hx = 16'h0000;
    logic [7:0] a = 8'h00;
    logic c = 1'b0;

    cpu_opcode_subset_exec uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .rdata_i(rd),
        .bus_o(bus), .done_o(done), .illegal_o(ill), .acc_o(acc), .index_o(idx),
        .sp_o(spo), .pc_o(pco), .flags_o(flg));
    bus_memory_model mem (.mclk_i(mclk_i), .bus_i(bus), .rdata_o(rd));

    initial
    begin
        forever #4 mclk_i = ~mclk_i;
    end

    function automatic logic [8:0] rmw(input logic [7:0] op, input logic [7:0] v, input logic ci);
        case (op[3:0])
            4'h0: return {v != 8'h00, 8'h00 - v};
            4'h9: return {v[7], v[6:0], ci};
            default: return {v[0], ci, v[7:1]};
        endcase
    endfunction

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (e !== g)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic pk(input logic [15:0] ad, input logic [7:0] v);
        mem.m[ad] = v;
        em[ad[8:0]] = v;
    endtask

    // program bytes go to memory, the expected length to the queue
    task automatic ins(input logic [23:0] code, input int n, input int cy);
        for (int i = 0; i < n; i++)
        begin
            pk(pc, code[23 - 8 * i -: 8]);
            pc++;
        end
        cq.push_back(cy);
        pq.push_back(pc); // next opcode address, shown while the closing fetch runs
    endtask

    task automatic mop(input logic [23:0] code, input int n, input int cy, input logic [15:0] ea);
        ins(code, n, cy);
        {c, em[ea[8:0]]} = rmw(n == 3 ? code[15:8] : code[23:16], em[ea[8:0]], c);
    endtask

    task automatic rop(input logic [7:0] op);
        ins({op, 16'h0000}, 1, 1);
        if (op[7:4] == 4'h4)
            {c, a} = rmw(op, a, c);
        else
            {c, hx[7:0]} = rmw(op, hx[7:0], c);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // each done pulse closes one instruction; the tail of idles must take one cycle each
    always @(negedge mclk_i)
    begin
        if (resetn_i)
            cnt++;
        if (resetn_i && done === 1'b1)
        begin
            // the warm-up idle at address zero owns no note in the queues
            if (go)
            begin
                ex = cq.size() > 0 ? cq.pop_front() : 1;
                chk("cycles", 16'(ex), 16'(cnt));
                if (pq.size() > 0)
                    chk("program counter", pq.pop_front(), pco);
            end
            chk("unknown opcode", 16'h0000, {15'h0000, ill});
            go = 1'b1;
            cnt = 0;
        end
    end

    // a hang is cut short well past the program's length
    initial
    begin
        #8000;
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        for (int i = 0; i < 512; i++)
            pk(16'(i), 8'h9D);
        r1 = 8'($random(seed));
        r2 = 8'($random(seed));
        r3 = 8'($random(seed));
        pk(16'h0080, r2);
        pk(16'h0091, r1);
        pk(16'h0100, 8'h90);
        ins(24'h880000, 1, 3);
        sp++;
        hx[7:0] = em[sp[8:0]];
        ins({8'hAA, r1, 8'h00}, 2, 2);
        a = r1;
        ins(24'hBA8000, 2, 3);
        a = a | r2;
        ins(24'h620000, 1, 1);
        a = {a[3:0], a[7:4]};
        ins(24'h870000, 1, 2);
        em[sp[8:0]] = a;
        sp--;
        ins(24'h890000, 1, 2);
        em[sp[8:0]] = hx[7:0];
        sp--;
        ins(24'h8B0000, 1, 2);
        em[sp[8:0]] = hx[15:8];
        sp--;
        ins(24'h8A0000, 1, 3);
        sp++;
        hx[15:8] = em[sp[8:0]];
        ins(24'h880000, 1, 3);
        sp++;
        hx[7:0] = em[sp[8:0]];
        ins(24'h860000, 1, 3);
        sp++;
        a = em[sp[8:0]];
        ins({8'h6E, r3, 8'h81}, 3, 4);
        em[9'h081] = r3;
        ins(24'h4E8182, 3, 5);
        em[9'h082] = r3;
        ins(24'h5E8000, 2, 5);
        em[hx[8:0]] = em[9'h080];
        hx++;
        ins(24'h7E8400, 2, 5);
        em[9'h084] = em[hx[8:0]];
        hx++;
        foreach (lo[k])
        begin
            mop({8'h30 | lo[k], 16'h8000}, 2, 5, 16'h0080);
            mop({8'h70 | lo[k], 16'h0000}, 1, 4, hx);
            mop({8'h60 | lo[k], 16'h1000}, 2, 5, hx + 16'h0010);
            mop({8'h9E, 8'h60 | lo[k], 8'h20}, 3, 6, sp + 16'h0020);
            rop(8'h40 | lo[k]);
            rop(8'h50 | lo[k]);
        end
        ins(24'h420000, 1, 5);
        {hx[7:0], a} = hx[7:0] * a;
        c = 1'b0;
        repeat (20) @(negedge mclk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 400 && cq.size() > 0; i++)
            @(negedge mclk_i);
        chk("pending", 16'h0000, 16'(cq.size()));
        repeat (4) @(negedge mclk_i);
        $display("program run finished");
        chk("acc", {8'h00, a}, {8'h00, acc});
        chk("index", hx, idx);
        chk("stack pointer", sp, spo);
        chk("carry", {15'h0000, c}, {15'h0000, flg[0]});
        for (int i = 0; i < 512; i++)
            chk("memory", {8'h00, em[i]}, {8'h00, mem.m[i]});
        $display("final state checked");
        tally_and_finish();
    end
endmodule
`default_nettype wire
